/* core/byte_alu_regs.vh */
// constants for the byte arithmetic unit and its condition flags
// assumes inclusion by bare name from every design file that needs it
`ifndef BYTE_ALU_REGS_VH
`define BYTE_ALU_REGS_VH

// ************************************
// operation codes
// ************************************
`define OP_W 4
`define OP_NOP 4'h0
`define OP_ADD 4'h1
`define OP_ADC 4'h2
`define OP_SUB 4'h3
`define OP_SBC 4'h4
`define OP_DAA 4'h5
`define OP_MASK_SET 4'h6
`define OP_MASK_CLR 4'h7
`define OP_FLAGS_WR 4'h8

// ************************************
// flag register layout
// ************************************
`define FLAG_W 6
`define FLAG_H 5
`define FLAG_I 4
`define FLAG_N 3
`define FLAG_Z 2
`define FLAG_V 1
`define FLAG_C 0
`define FLAGS_RST 6'h10

// ************************************
// register map
// ************************************
`define ADDR_W 2
`define REG_FLAGS 2'h0
`define REG_ACC 2'h1
`define REG_OPND 2'h2
`define REG_OP 2'h3

// ************************************
// decimal adjust constants
// ************************************
`define BCD_NINE 4'h9
`define DAA_LO 8'h06
`define DAA_HI 8'h60
`define BYTE_ZERO 8'h00

`endif

/* core/byte_adder.v */
// eight-bit adder with carry in, carry out of bit 7 and out of bit 3
// assumes purely combinational use by the arithmetic unit
`timescale 1ns/1ps
module byte_adder #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] a,
  input wire [WIDTH-1:0] b,
  input wire cin,
  output wire [WIDTH-1:0] sum,
  output wire cout,
  output wire half_cout
);
  wire [WIDTH:0] carry;
  assign carry[0] = cin;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : bit_g
      assign sum[i] = a[i] ^ b[i] ^ carry[i];
      assign carry[i+1] = (a[i] & b[i]) | (carry[i] & (a[i] ^ b[i]));
    end
  endgenerate
  assign cout = carry[WIDTH];
  assign half_cout = carry[4];
endmodule

/* core/byte_alu_flags.v */
// eight-bit arithmetic unit with accumulator and six-bit condition flags
// assumes a sequencer issues one operation per strobe and reads back over a plain port
// How it works
// - plain binary addition of two 8-bit two's complement operands.
// - sign and overflow flags support signed bytes, bit 7 the sign.
// - carry flag supports unsigned bytes from 0 to 255.
// - unpacked decimal: one digit in low nibble, upper nibble zero.
// - packed decimal: tens in bits 7-4, units in bits 3-0.
// - six flags, bit 5 down: half-carry, mask, sign, zero, overflow, carry.
// - mask set by interrupt or mask-set op, cleared by mask-clear op, loaded from bit 4 by a flag register write.
// - sign flag takes result bit 7.
// - zero flag set when all eight result bits are zero.
// - carry flag set on carry out of bit 7 for adds.
// - add overflow only when operand signs match and result sign differs.
// - subtract by adding two's complement of subtrahend.
// - subtract overflow uses the inverted subtrahend sign.
// - carry acts as carry on add and borrow on subtract.
// - carry forms add the carry flag, borrow forms subtract it.
// - accumulator holds first operand and receives the result.
// - decimal adjust corrects accumulator and carry after BCD add.
// - decimal adjust adds 00, 06, 60 or 66 hex.
// - adjust sets carry if upper digit exceeds nine, never clears it.
`timescale 1ns/1ps
`include "byte_alu_regs.vh"

module byte_alu_flags #(
  parameter WIDTH = 8
) (
  input wire core_clk,
  input wire rstn,
  input wire [`ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  input wire op_valid,
  input wire [`OP_W-1:0] op_code,
  input wire [WIDTH-1:0] operand,
  input wire acc_load,
  input wire [WIDTH-1:0] acc_in,
  input wire irq_taken,
  output reg [WIDTH-1:0] acc_out,
  output reg [`FLAG_W-1:0] flags_out,
  output reg op_done
);

// ************************************
// state
// ************************************
  reg [WIDTH-1:0] acc_r;
  reg [WIDTH-1:0] acc_nxt;
  reg [`FLAG_W-1:0] flags_r;
  reg [`FLAG_W-1:0] flags_nxt;
  reg [WIDTH-1:0] opnd_r;
  reg [`OP_W-1:0] last_op_r;
  reg [WIDTH-1:0] acc_upd;
  reg [7:0] rd_mux;
  reg h_nxt;
  reg i_nxt;
  reg n_nxt;
  reg z_nxt;
  reg v_nxt;
  reg c_nxt;

// ************************************
// register port decode
// ************************************
  wire wr_flags = wr_en && (addr == `REG_FLAGS);
  wire wr_acc = wr_en && (addr == `REG_ACC);
  wire wr_opnd = wr_en && (addr == `REG_OPND);

// ************************************
// operation select
// ************************************
  // register-port writes of the op register issue an operation too
  wire sw_op = wr_en && (addr == `REG_OP);
  wire go = op_valid || sw_op;
  wire [`OP_W-1:0] op = op_valid ? op_code : wdata[`OP_W-1:0];
  wire [WIDTH-1:0] opnd = op_valid ? operand : opnd_r;
  wire is_sub = (op == `OP_SUB) || (op == `OP_SBC);
  wire use_c = (op == `OP_ADC) || (op == `OP_SBC);
  wire c_in = flags_r[`FLAG_C];

// ************************************
// adder
// ************************************
  // complement subtrahend
  wire [WIDTH-1:0] b_in = is_sub ? ~opnd : opnd;
  wire add_cin = is_sub ? ~(use_c & c_in) : (use_c & c_in);
  wire [WIDTH-1:0] sum;
  wire cout;
  wire hcout;

  byte_adder #(.WIDTH(WIDTH)) adder_u (
    .a(acc_r),
    .b(b_in),
    .cin(add_cin),
    .sum(sum),
    .cout(cout),
    .half_cout(hcout)
  );

// ************************************
// decimal adjust
// ************************************
  // packed or unpacked digits
  wire [3:0] lo_dig = acc_r[3:0];
  wire [3:0] hi_dig = acc_r[7:4];
  wire lo_fix = flags_r[`FLAG_H] || (lo_dig > `BCD_NINE);
  // upper digit of nine needs fixing too when the low fix will carry into it
  wire hi_fix = c_in || (hi_dig > `BCD_NINE) ||
    ((hi_dig == `BCD_NINE) && (lo_dig > `BCD_NINE));
  wire [7:0] daa_corr = (lo_fix ? `DAA_LO : `BYTE_ZERO) | (hi_fix ? `DAA_HI : `BYTE_ZERO);
  wire [8:0] daa_sum = {1'b0, acc_r[7:0]} + {1'b0, daa_corr};
  wire [7:0] daa_acc = daa_sum[7:0];
  wire daa_n = daa_acc[7];
  wire daa_z = (daa_acc == `BYTE_ZERO);
  // carry never cleared
  // a sixty correction always means the tens digit went past nine
  wire daa_c = c_in | hi_fix | daa_sum[8];

// ************************************
// arithmetic flags
// ************************************
  // zero chain per bit
  wire [WIDTH:0] zero_run;
  assign zero_run[0] = 1'b1;
  genvar zi;
  generate
    for (zi = 0; zi < WIDTH; zi = zi + 1) begin : zero_g
      assign zero_run[zi+1] = zero_run[zi] & ~sum[zi];
    end
  endgenerate
  wire arith_z = zero_run[WIDTH];

  wire arith_n = sum[WIDTH-1];

  // overflow from signs
  // b_in already holds the inverted subtrahend sign on subtracts
  wire acc_sign = acc_r[WIDTH-1];
  wire opb_sign = b_in[WIDTH-1];
  wire arith_v = (acc_sign == opb_sign) && (arith_n != acc_sign);

  wire arith_c = is_sub ? ~cout : cout;

  // half-carry on adds
  // kept through subtracts so a later adjust still sees the last add
  wire arith_h = is_sub ? flags_r[`FLAG_H] : hcout;

// ************************************
// operation decode
// ************************************
  // undecoded codes run as no-operation, flags and accumulator kept
  wire is_add = (op == `OP_ADD) || (op == `OP_ADC);
  wire do_arith = go && (is_add || is_sub);
  wire do_daa = go && (op == `OP_DAA);
  wire do_mask_set = go && (op == `OP_MASK_SET);
  wire do_mask_clr = go && (op == `OP_MASK_CLR);

  // a flag write beside an operation is dropped, the operation owns the flags
  wire do_flag_wr = wr_flags && !go;

// ************************************
// next state
// ************************************
  // result to accumulator
  always @* begin
    acc_nxt = acc_r;
    if (do_arith)
      acc_nxt = sum;
    else if (do_daa)
      acc_nxt = daa_acc;
  end

  // load, write, then result
  // a port write beside an operation is dropped so the result survives
  always @* begin
    acc_upd = acc_nxt;
    if (acc_load)
      acc_upd = acc_in;
    else if (wr_acc && !go)
      acc_upd = wdata[WIDTH-1:0];
  end

  always @* begin
    h_nxt = flags_r[`FLAG_H];
    if (do_flag_wr)
      h_nxt = wdata[`FLAG_H];
    else if (do_arith)
      h_nxt = arith_h;
  end

  // mask set and clear
  // interrupt applied last so it wins over a clear in the same cycle
  always @* begin
    i_nxt = flags_r[`FLAG_I];
    if (do_flag_wr)
      i_nxt = wdata[`FLAG_I];
    else if (do_mask_clr)
      i_nxt = 1'b0;
    else if (do_mask_set)
      i_nxt = 1'b1;
    if (irq_taken)
      i_nxt = 1'b1;
  end

  always @* begin
    n_nxt = flags_r[`FLAG_N];
    if (do_flag_wr)
      n_nxt = wdata[`FLAG_N];
    else if (do_arith)
      n_nxt = arith_n;
    else if (do_daa)
      n_nxt = daa_n;
  end

  always @* begin
    z_nxt = flags_r[`FLAG_Z];
    if (do_flag_wr)
      z_nxt = wdata[`FLAG_Z];
    else if (do_arith)
      z_nxt = arith_z;
    else if (do_daa)
      z_nxt = daa_z;
  end

  // overflow flag
  // the adjust leaves overflow alone
  always @* begin
    v_nxt = flags_r[`FLAG_V];
    if (do_flag_wr)
      v_nxt = wdata[`FLAG_V];
    else if (do_arith)
      v_nxt = arith_v;
  end

  always @* begin
    c_nxt = flags_r[`FLAG_C];
    if (do_flag_wr)
      c_nxt = wdata[`FLAG_C];
    else if (do_arith)
      c_nxt = arith_c;
    else if (do_daa)
      c_nxt = daa_c;
  end

  always @* begin
    flags_nxt = {h_nxt, i_nxt, n_nxt, z_nxt, v_nxt, c_nxt};
  end

// ************************************
// registers
// ************************************
  // flag, accumulator, operand and last operation registers
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= {WIDTH{1'b0}};
      flags_r <= `FLAGS_RST;
      opnd_r <= {WIDTH{1'b0}};
      last_op_r <= `OP_NOP;
    end else begin
      flags_r <= flags_nxt;
      acc_r <= acc_upd;
      if (wr_opnd)
        opnd_r <= wdata[WIDTH-1:0];
      if (go)
        last_op_r <= op;
    end
  end

// ************************************
// read port
// ************************************
  // plain mux on the address; the strobe only gates it at the output flop
  always @* begin
    rd_mux = `BYTE_ZERO;
    case (addr)
      `REG_FLAGS: rd_mux = {2'b00, flags_r};
      `REG_ACC: rd_mux = acc_r;
      `REG_OPND: rd_mux = opnd_r;
      `REG_OP: rd_mux = {4'h0, last_op_r};
      default: rd_mux = `BYTE_ZERO;
    endcase
  end

// ************************************
// outputs
// ************************************
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acc_out <= {WIDTH{1'b0}};
      flags_out <= `FLAGS_RST;
      op_done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      // pins mirror the registers so every output leaves a flip-flop
      acc_out <= acc_upd;
      flags_out <= flags_nxt;
      op_done <= go;
      // unread cycles show zero, so a stale word never looks like an answer
      rdata <= rd_en ? rd_mux : `BYTE_ZERO;
    end
  end

endmodule

/* verification/alu_chk_sva.sv */
// port assertions for the byte arithmetic unit
// assumes a bind into the unit, one clock
`timescale 1ns/1ps
module alu_chk (
  input wire core_clk,
  input wire rstn,
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [7:0] operand,
  input wire acc_load,
  input wire wr_en,
  input wire irq_taken,
  input wire [7:0] acc_out,
  input wire [5:0] flags_out
);
  // ****
  // helpers
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // a load wins over any result, so leave those cycles out
  wire go = op_valid && !acc_load;
  wire add = go && op_code == 4'h1;
  wire adc = go && op_code == 4'h2;
  wire sub = go && op_code == 4'h3;
  wire [8:0] s = acc_out + operand;
  wire [8:0] c = acc_out + operand + flags_out[0];
  wire [8:0] d = acc_out - operand;
  wire [4:0] h = acc_out[3:0] + operand[3:0];
  // ****
  // properties
  // ****
  a_add_sum: assert property (add |=>
    acc_out == $past(s[7:0]) && flags_out[0] == $past(s[8])) else $error("add sum");
  a_add_ovf: assert property (add |=> flags_out[1] ==
    $past(acc_out[7] == operand[7] && s[7] != acc_out[7])) else $error("add ovf");
  a_half_carry: assert property (add |=> flags_out[5] == $past(h[4]))
    else $error("half carry");
  a_adc_sum: assert property (adc |=>
    acc_out == $past(c[7:0]) && flags_out[0] == $past(c[8])) else $error("adc sum");
  a_sub_diff: assert property (sub |=>
    acc_out == $past(d[7:0]) && flags_out[0] == $past(d[8])) else $error("sub diff");
  a_sub_ovf: assert property (sub |=> flags_out[1] ==
    $past(acc_out[7] != operand[7] && d[7] != acc_out[7])) else $error("sub ovf");
  a_sign_zero: assert property (add || sub |=>
    flags_out[3] == acc_out[7] && flags_out[2] == (acc_out == 8'h00)) else $error("n z");
  a_irq_mask: assert property (irq_taken |=> flags_out[4]) else $error("irq mask");
  a_mask_kept: assert property (flags_out[4] && !wr_en && !(op_valid &&
    op_code == 4'h7) |=> flags_out[4]) else $error("mask kept");
endmodule

/* verification/seq_model.sv */
// sequencer and accumulator source for the operation port
// assumes tasks are called by the bench, one at a time
`timescale 1ns/1ps
module seq_model (
  input wire core_clk,
  output reg op_valid,
  output reg [3:0] op_code,
  output reg [7:0] operand,
  output reg acc_load,
  output reg [7:0] acc_in
);
  initial begin
    op_valid = 1'b0;
    op_code = 4'h0;
    operand = 8'h00;
    acc_load = 1'b0;
    acc_in = 8'h00;
  end
  // released data buses show the inverse; op_code keeps its last value
  task load(input [7:0] v);
    begin
      @(posedge core_clk);
      acc_load <= 1'b1;
      acc_in <= v;
      @(posedge core_clk);
      acc_load <= 1'b0;
      acc_in <= ~v;
    end
  endtask
  task issue(input [3:0] op, input [7:0] v);
    begin
      @(posedge core_clk);
      op_valid <= 1'b1;
      op_code <= op;
      operand <= v;
      @(posedge core_clk);
      op_valid <= 1'b0;
      operand <= ~v;
    end
  endtask
endmodule

/* verification/tb_byte_alu_condition_flags.sv */
// top bench for the byte arithmetic unit
// assumes checker and sequencer model compiled first
`timescale 1ns/1ps
module tb_byte_alu_condition_flags;
  reg core_clk = 1'b0;
  reg rstn;
  reg [1:0] addr;
  reg [7:0] wdata;
  reg wr_en;
  reg rd_en;
  reg irq_taken;
  wire op_valid, acc_load, op_done;
  wire [3:0] op_code;
  wire [7:0] operand, acc_in, acc_out, rdata;
  wire [5:0] flags_out;
  integer errors = 0;
  integer tests_run = 0;
  always #4 core_clk = ~core_clk;
  seq_model seq (.core_clk(core_clk), .op_valid(op_valid), .op_code(op_code),
    .operand(operand), .acc_load(acc_load), .acc_in(acc_in));
  byte_alu_flags dut (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .op_valid(op_valid), .op_code(op_code),
    .operand(operand), .acc_load(acc_load), .acc_in(acc_in), .irq_taken(irq_taken),
    .acc_out(acc_out), .flags_out(flags_out), .op_done(op_done));
  // ****
  // shared tasks
  // ****
  task chk(input [63:0] n, input [7:0] e, input [7:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("ERROR %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task t_op(input [3:0] op, input [7:0] v, input [7:0] ea, input [5:0] ef);
    begin
      seq.issue(op, v);
      #1;
      chk("done", 8'h01, {7'h0, op_done});
      chk("acc", ea, acc_out);
      chk("flags", {2'h0, ef}, {2'h0, flags_out});
      @(posedge core_clk);
      #1;
      chk("done", 8'h00, {7'h0, op_done});
    end
  endtask
  task wr(input [1:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge core_clk);
      wr_en <= 1'b0;
    end
  endtask
  task rd(input [1:0] a, input [7:0] e);
    begin
      @(posedge core_clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1;
      chk("rdata", e, rdata);
    end
  endtask
  // ****
  // scenarios
  // ****
  task t_arith;
    begin
      rd(2'h0, 8'h10);
      seq.load(8'haa);
      t_op(4'h1, 8'hcc, 8'h76, 6'h33);
      t_op(4'h2, 8'hcc, 8'h43, 6'h31);
      seq.load(8'h80);
      t_op(4'h3, 8'h01, 8'h7f, 6'h32);
      seq.load(8'h00);
      t_op(4'h3, 8'h01, 8'hff, 6'h39);
      t_op(4'h4, 8'h00, 8'hfe, 6'h38);
      seq.load(8'h05);
      t_op(4'h3, 8'h05, 8'h00, 6'h34);
      $display("test arith done");
    end
  endtask
  task t_bcd;
    begin
      seq.load(8'h27);
      t_op(4'h1, 8'h35, 8'h5c, 6'h10);
      t_op(4'h5, 8'h00, 8'h62, 6'h10);
      seq.load(8'h99);
      t_op(4'h1, 8'h01, 8'h9a, 6'h18);
      t_op(4'h5, 8'h00, 8'h00, 6'h15);
      $display("test bcd done");
    end
  endtask
  task t_mask;
    begin
      t_op(4'h7, 8'h00, 8'h00, 6'h05);
      @(posedge core_clk);
      irq_taken <= 1'b1;
      @(posedge core_clk);
      irq_taken <= 1'b0;
      #1;
      chk("irq", 8'h15, {2'h0, flags_out});
      t_op(4'h7, 8'h00, 8'h00, 6'h05);
      t_op(4'h6, 8'h00, 8'h00, 6'h15);
      wr(2'h0, 8'h2a);
      rd(2'h0, 8'h2a);
      wr(2'h1, 8'h40);
      wr(2'h2, 8'h02);
      wr(2'h3, 8'h01);
      rd(2'h1, 8'h42);
      rd(2'h0, 8'h00);
      rd(2'h2, 8'h02);
      rd(2'h3, 8'h01);
      $display("test mask done");
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    rstn = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    irq_taken = 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_arith;
    t_bcd;
    t_mask;
    wrap_up;
  end
  // a hang costs one mismatch
  initial begin
    #100000;
    errors = errors + 1;
    wrap_up;
  end
endmodule
bind byte_alu_flags alu_chk u_chk (.core_clk(core_clk), .rstn(rstn), .op_valid(op_valid),
  .op_code(op_code), .operand(operand), .acc_load(acc_load), .wr_en(wr_en),
  .irq_taken(irq_taken), .acc_out(acc_out), .flags_out(flags_out));
